// ### core/tsq_defines.svh
// constants for the measurement trigger sequencer: offsets, fields, resets
// assumes a 100 MHz mclk; time settings are held in milliseconds
`ifndef TSQ_DEFINES_SVH
`define TSQ_DEFINES_SVH

// register byte offsets
`define TSQ_REG_CTRL      8'h00
`define TSQ_REG_CMD       8'h04
`define TSQ_REG_INTERVAL  8'h08
`define TSQ_REG_DELAY     8'h0c
`define TSQ_REG_FILT      8'h10
`define TSQ_REG_WINDOW    8'h14
`define TSQ_REG_HOLDN     8'h18
`define TSQ_REG_CHLAST    8'h1c
`define TSQ_REG_STATUS    8'h20
`define TSQ_REG_READING   8'h24

// control register fields
`define TSQ_CTRL_CONT     0
`define TSQ_CTRL_SRC_LSB  1
`define TSQ_CTRL_AUTO     4
`define TSQ_CTRL_SCAN     5
`define TSQ_CTRL_FREP     6
`define TSQ_CTRL_HOLD     7
`define TSQ_CTRL_REMOTE   8
`define TSQ_CTRL_FR_LSB   9

// command register fields (write only, self clearing)
`define TSQ_CMD_INIT      0
`define TSQ_CMD_ABORT     1
`define TSQ_CMD_BUSTRG    2
`define TSQ_CMD_RESET     3
`define TSQ_CMD_RECALL    4
`define TSQ_CMD_PRESET    5

// timing and limits
`define TSQ_CLK_NS        10
`define TSQ_MS_NS         1000000
`define TSQ_INTERVAL_DEF  30'h0000_0064
`define TSQ_INTERVAL_MIN  30'h0000_0001
`define TSQ_TIME_MAX      30'h3b9a_c9ff
`define TSQ_WIN_MIN       11'h001
`define TSQ_WIN_MAX       11'h7d0
`define TSQ_WIN_DEF       11'h00a
`define TSQ_WIN_SCALE     48'h0000_0000_2710
`define TSQ_HOLDN_MIN     7'h02
`define TSQ_HOLDN_MAX     7'h64
`define TSQ_HOLDN_DEF     7'h05
`define TSQ_FILT_DEF      8'h0a
`define TSQ_CHLAST_DEF    8'h0a

`endif

// ### core/tsq_pkg.sv
// types shared by the measurement trigger sequencer
// assumes tsq_defines.svh carries the register, field and timing constants
package tsq_pkg;

  typedef enum logic [2:0] {
    TSQ_IDLE  = 3'b000,
    TSQ_EVENT = 3'b001,
    TSQ_DELAY = 3'b010,
    TSQ_CONV  = 3'b011,
    TSQ_WAIT  = 3'b100,
    TSQ_OPEN  = 3'b101,
    TSQ_CLOSE = 3'b110,
    TSQ_NEXT  = 3'b111
  } tsq_state_e;

  typedef enum logic [2:0] {
    TSQ_SRC_IMM   = 3'b000,
    TSQ_SRC_KEY   = 3'b001,
    TSQ_SRC_TIMER = 3'b010,
    TSQ_SRC_EXT   = 3'b011,
    TSQ_SRC_BUS   = 3'b100
  } tsq_src_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tsq_bus_s;

  typedef struct packed {
    logic       open;
    logic       close;
    logic [7:0] num;
  } tsq_chan_s;

  typedef struct packed {
    tsq_state_e         st;
    logic [2:0]         key_sy;
    logic [2:0]         ext_sy;
    logic               cont;
    tsq_src_e           src;
    logic               auto_dly;
    logic               scan_en;
    logic               filt_rep;
    logic               hold_en;
    logic               remote;
    logic [2:0]         fr;
    logic [29:0]        interval;
    logic [29:0]        delay;
    logic [7:0]         filt_n;
    logic [10:0]        window;
    logic [6:0]         hold_n;
    logic [7:0]         chan_last;
    logic [31:0]        pre;
    logic [29:0]        tmr;
    logic               first;
    logic [29:0]        dcnt;
    logic [7:0]         fcnt;
    logic signed [31:0] acc;
    logic signed [23:0] seed;
    logic               seed_ok;
    logic [6:0]         hcnt;
    logic [7:0]         chan;
    logic               chan_closed;
    logic [31:0]        rdata;
    logic               conv_start;
    logic               rdg_valid;
    logic signed [23:0] rdg;
    logic               beep;
    tsq_chan_s          chan_o;
    logic               idle;
  } tsq_state_s;

endpackage : tsq_pkg

// ### core/tsq_core.sv
// measurement trigger sequencer: idle, event wait, delay, device action
// assumes one mclk domain; key and sync pins are async, the converter and
// register port are on mclk
//
// Overview of operation
// - idle state starts no conversion and no channel switching
// - initiate command or continuous mode takes the sequencer out of idle
// - continuous mode re-arms after the action instead of going idle
// - reset, abort, recall or preset commands force idle at any time
// - immediate source satisfies the event wait at once
// - front key fires the event only while in local control
// - interval source passes first time, later only after the interval
// - interval source waits only while scanning; outside scanning it passes at once
// - interval timer clears in idle and outside scan operation
// - external sync input pulse satisfies the event wait
// - bus trigger command satisfies the event wait
// - after the event wait a programmed or automatic delay elapses
// - automatic delay length follows the function and range code
// - repeat filter averages the programmed count of conversions
// - moving filter or no filter takes exactly one conversion
// - settle check keeps the first reading as reference and loops
// - later readings inside the window loop the action again
// - settle check releases after the programmed count, 2 to 100
// - a reading outside the window restarts with a new reference
// - release of the settle check pulses the audible alert
// - scanning opens the previous channel then closes the next
// - interval defaults to 100 ms with a 1 ms minimum
`timescale 1ns/100ps
`include "tsq_defines.svh"

module tsq_core #(
  parameter int MS_CYCLES = `TSQ_MS_NS / `TSQ_CLK_NS // cycles per ms
) (
  input  wire logic               mclk,        // system clock
  input  wire logic               rst_n,       // async reset, active low
  input  wire tsq_pkg::tsq_bus_s  bus,         // register port request
  output      logic [31:0]        rdata,       // read data, cycle after rd
  input  wire logic               fire_key,    // front_panel_fire_key pin
  input  wire logic               ext_front_panel_fire_key,    // external sync input pin
  output      logic               conv_start,  // start one conversion
  input  wire logic               conv_valid,  // conversion result strobe
  input  wire logic signed [23:0] conv_value,  // conversion result
  output      logic               rdg_valid,   // processed reading strobe
  output      logic signed [23:0] rdg,         // processed reading
  output      logic               beep,        // settle release alert
  output      tsq_pkg::tsq_chan_s chan,        // channel open/close pulses
  output      logic               idle         // sequencer is idle
);
  import tsq_pkg::*;

  tsq_state_s s;
  tsq_state_s next_s;
  logic       cmd_wr;
  logic       cmd_abort;

  // command strobes decoded straight from the port
  assign cmd_wr    = bus.wr && (bus.addr == `TSQ_REG_CMD);
  assign cmd_abort = cmd_wr && (bus.wdata[`TSQ_CMD_ABORT]
                     || bus.wdata[`TSQ_CMD_RESET]
                     || bus.wdata[`TSQ_CMD_RECALL]
                     || bus.wdata[`TSQ_CMD_PRESET]);

  // next-state logic for the whole block
  always_comb begin
    logic               tick;
    logic               key_edge;
    logic               ext_edge;
    logic               fired;
    logic [29:0]        dly;
    logic [29:0]        v30;
    logic signed [31:0] sum;
    logic signed [23:0] val;
    logic signed [24:0] diff;
    logic [47:0]        lhs;
    logic [47:0]        rhs;
    logic               in_win;
    logic [7:0]         nch;
    tick     = 1'b0;
    key_edge = 1'b0;
    ext_edge = 1'b0;
    fired    = 1'b0;
    dly      = '0;
    v30      = '0;
    sum      = '0;
    val      = '0;
    diff     = '0;
    lhs      = '0;
    rhs      = '0;
    in_win   = 1'b0;
    nch      = '0;
    next_s   = s;
    next_s.conv_start  = 1'b0;
    next_s.rdg_valid   = 1'b0;
    next_s.beep        = 1'b0;
    next_s.chan_o.open  = 1'b0;
    next_s.chan_o.close = 1'b0;
    next_s.rdata       = '0;

    // two-flop synchronisers plus a third flop; the second and third stages feed edge logic
    next_s.key_sy = {s.key_sy[1:0], fire_key};
    next_s.ext_sy = {s.ext_sy[1:0], ext_front_panel_fire_key};
    key_edge = s.key_sy[1] && !s.key_sy[2];
    ext_edge = s.ext_sy[1] && !s.ext_sy[2];

    // millisecond prescaler shared by interval and delay
    tick = (s.pre == 32'(MS_CYCLES - 1));
    next_s.pre = tick ? '0 : s.pre + 32'h1;

    // interval timer only runs while scanning and armed
    if (s.st == TSQ_IDLE || !s.scan_en) begin
      next_s.tmr = '0;
    end else if (tick && s.tmr != `TSQ_TIME_MAX) begin
      next_s.tmr = s.tmr + 30'h1;
    end

    // register writes; time values are clamped into their legal range
    if (bus.wr) begin
      v30 = bus.wdata[29:0];
      unique case (bus.addr)
        `TSQ_REG_CTRL: begin
          next_s.cont     = bus.wdata[`TSQ_CTRL_CONT];
          next_s.src      = tsq_src_e'(bus.wdata[`TSQ_CTRL_SRC_LSB +: 3]);
          next_s.auto_dly = bus.wdata[`TSQ_CTRL_AUTO];
          next_s.scan_en  = bus.wdata[`TSQ_CTRL_SCAN];
          next_s.filt_rep = bus.wdata[`TSQ_CTRL_FREP];
          next_s.hold_en  = bus.wdata[`TSQ_CTRL_HOLD];
          next_s.remote   = bus.wdata[`TSQ_CTRL_REMOTE];
          next_s.fr       = bus.wdata[`TSQ_CTRL_FR_LSB +: 3];
        end
        `TSQ_REG_INTERVAL: begin
          if (v30 < `TSQ_INTERVAL_MIN) begin
            next_s.interval = `TSQ_INTERVAL_MIN;
          end else if (v30 > `TSQ_TIME_MAX) begin
            next_s.interval = `TSQ_TIME_MAX;
          end else begin
            next_s.interval = v30;
          end
        end
        `TSQ_REG_DELAY: begin
          next_s.delay = (v30 > `TSQ_TIME_MAX) ? `TSQ_TIME_MAX : v30;
        end
        `TSQ_REG_FILT: begin
          // a zero count would divide by zero, so it means one
          next_s.filt_n = (bus.wdata[7:0] == 8'h00) ? 8'h01 : bus.wdata[7:0];
        end
        `TSQ_REG_WINDOW: begin
          if (bus.wdata[10:0] < `TSQ_WIN_MIN || bus.wdata[31:11] != '0) begin
            next_s.window = (bus.wdata[31:11] != '0) ? `TSQ_WIN_MAX
                                                     : `TSQ_WIN_MIN;
          end else if (bus.wdata[10:0] > `TSQ_WIN_MAX) begin
            next_s.window = `TSQ_WIN_MAX;
          end else begin
            next_s.window = bus.wdata[10:0];
          end
        end
        `TSQ_REG_HOLDN: begin
          if (bus.wdata[6:0] < `TSQ_HOLDN_MIN && bus.wdata[31:7] == '0) begin
            next_s.hold_n = `TSQ_HOLDN_MIN;
          end else if (bus.wdata[6:0] > `TSQ_HOLDN_MAX
                       || bus.wdata[31:7] != '0) begin
            next_s.hold_n = `TSQ_HOLDN_MAX;
          end else begin
            next_s.hold_n = bus.wdata[6:0];
          end
        end
        `TSQ_REG_CHLAST: begin
          next_s.chan_last = (bus.wdata[7:0] == 8'h00) ? 8'h01
                                                       : bus.wdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // register reads; unmapped offsets read zero
    if (bus.rd) begin
      unique case (bus.addr)
        `TSQ_REG_CTRL: begin
          next_s.rdata = {20'h0, s.fr, s.remote, s.hold_en, s.filt_rep,
                          s.scan_en, s.auto_dly, s.src, s.cont};
        end
        `TSQ_REG_INTERVAL: next_s.rdata = {2'b00, s.interval};
        `TSQ_REG_DELAY:    next_s.rdata = {2'b00, s.delay};
        `TSQ_REG_FILT:     next_s.rdata = {24'h0, s.filt_n};
        `TSQ_REG_WINDOW:   next_s.rdata = {21'h0, s.window};
        `TSQ_REG_HOLDN:    next_s.rdata = {25'h0, s.hold_n};
        `TSQ_REG_CHLAST:   next_s.rdata = {24'h0, s.chan_last};
        `TSQ_REG_STATUS: begin
          next_s.rdata = {7'h0, s.chan_closed, s.chan, 3'h0, s.hcnt,
                          s.seed_ok, s.first, s.idle, s.st};
        end
        `TSQ_REG_READING:  next_s.rdata = {{8{s.rdg[23]}}, s.rdg};
        default:           next_s.rdata = '0;
      endcase
    end

    // event sources; a bus trigger outside the event wait is dropped
    unique case (s.src)
      TSQ_SRC_IMM:   fired = 1'b1;
      TSQ_SRC_KEY:   fired = key_edge && !s.remote;
      TSQ_SRC_TIMER: fired = !s.scan_en || s.first
                             || (s.tmr >= s.interval);
      TSQ_SRC_EXT:   fired = ext_edge;
      TSQ_SRC_BUS:   fired = cmd_wr && bus.wdata[`TSQ_CMD_BUSTRG];
      default:       fired = 1'b0;
    endcase

    // automatic delay doubles per function/range code, in ms
    dly = s.auto_dly ? (30'h1 << s.fr) : s.delay;

    // raw conversion result and the next channel of the scan list
    val  = conv_value;
    nch  = (s.chan >= s.chan_last) ? 8'h01 : s.chan + 8'h01;

    unique case (s.st)
      TSQ_IDLE: begin
        // nothing runs here; leaving needs init or continuous mode
        if ((cmd_wr && bus.wdata[`TSQ_CMD_INIT]) || s.cont) begin
          next_s.st    = TSQ_EVENT;
          next_s.first = 1'b1;
        end
      end
      TSQ_EVENT: begin
        if (fired) begin
          next_s.first = 1'b0;
          next_s.tmr   = '0;
          next_s.dcnt  = '0;
          next_s.st    = TSQ_DELAY;
        end
      end
      TSQ_DELAY: begin
        if (s.dcnt >= dly) begin
          next_s.st = TSQ_CONV;
        end else if (tick) begin
          next_s.dcnt = s.dcnt + 30'h1;
        end
      end
      TSQ_CONV: begin
        next_s.conv_start = 1'b1;
        next_s.st         = TSQ_WAIT;
      end
      TSQ_WAIT: begin
        if (conv_valid) begin
          if (s.filt_rep && (s.fcnt + 8'h01) < s.filt_n) begin
            next_s.acc  = s.acc + 32'(val);
            next_s.fcnt = s.fcnt + 8'h01;
            next_s.st   = TSQ_CONV;
          end else begin
            sum = s.acc + 32'(val);
            if (s.filt_rep) begin
              val = 24'(sum / $signed({24'h0, s.filt_n}));
            end
            next_s.acc  = '0;
            next_s.fcnt = '0;
            // window test on the filtered value, not the last raw one:
            // |v - seed| * scale <= |seed| * window
            diff   = 25'(val) - 25'(s.seed);
            lhs    = 48'(diff[24] ? -diff : diff) * `TSQ_WIN_SCALE;
            rhs    = 48'(s.seed[23] ? -25'(s.seed) : 25'(s.seed))
                     * 48'(s.window);
            in_win = (lhs <= rhs);
            if (!s.hold_en) begin
              next_s.rdg_valid = 1'b1;
              next_s.rdg       = val;
              next_s.st        = TSQ_OPEN;
            end else if (!s.seed_ok || !in_win) begin
              next_s.seed    = val;
              next_s.seed_ok = 1'b1;
              next_s.hcnt    = '0;
              next_s.st      = TSQ_CONV;
            end else if ((s.hcnt + 7'h01) < s.hold_n) begin
              next_s.hcnt = s.hcnt + 7'h01;
              next_s.st   = TSQ_CONV;
            end else begin
              next_s.beep      = 1'b1;
              next_s.rdg_valid = 1'b1;
              next_s.rdg       = val;
              next_s.seed_ok   = 1'b0;
              next_s.hcnt      = '0;
              next_s.st        = TSQ_OPEN;
            end
          end
        end
      end
      TSQ_OPEN: begin
        if (s.scan_en && s.chan_closed) begin
          next_s.chan_o.open  = 1'b1;
          next_s.chan_o.num   = s.chan;
          next_s.chan_closed  = 1'b0;
        end
        next_s.st = s.scan_en ? TSQ_CLOSE : TSQ_NEXT;
      end
      TSQ_CLOSE: begin
        next_s.chan_o.close = 1'b1;
        next_s.chan_o.num   = nch;
        next_s.chan         = nch;
        next_s.chan_closed  = 1'b1;
        next_s.st           = TSQ_NEXT;
      end
      TSQ_NEXT: begin
        // a scan pass ends on the last channel of the list
        if (s.cont || (s.scan_en && s.chan != s.chan_last)) begin
          next_s.st = TSQ_EVENT;
        end else begin
          next_s.st = TSQ_IDLE;
        end
      end
    endcase

    // stop requests win over the next state and squash conversion and channel pulses
    if (cmd_abort) begin
      next_s.st           = TSQ_IDLE;
      next_s.conv_start   = 1'b0;
      next_s.chan_o.open  = 1'b0;
      next_s.chan_o.close = 1'b0;
      next_s.acc          = '0;
      next_s.fcnt         = '0;
      next_s.hcnt         = '0;
      next_s.seed_ok      = 1'b0;
    end
    next_s.idle = (next_s.st == TSQ_IDLE);
  end

  // the single state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.interval  <= `TSQ_INTERVAL_DEF;
      s.window    <= `TSQ_WIN_DEF;
      s.hold_n    <= `TSQ_HOLDN_DEF;
      s.filt_n    <= `TSQ_FILT_DEF;
      s.chan_last <= `TSQ_CHLAST_DEF;
      s.idle      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata      = s.rdata;
  assign conv_start = s.conv_start;
  assign rdg_valid  = s.rdg_valid;
  assign rdg        = s.rdg;
  assign beep       = s.beep;
  assign chan       = s.chan_o;
  assign idle       = s.idle;

  // checks on the sequencer's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_idle_quiet: assert property (s.st == TSQ_IDLE |->
    !conv_start && !chan.close && !chan.open)
    else $error("activity while idle");
  a_init_leaves: assert property (s.st == TSQ_IDLE && cmd_wr
    && bus.wdata[`TSQ_CMD_INIT] && !cmd_abort |=> s.st == TSQ_EVENT)
    else $error("initiate did not leave idle");
  a_cont_rearm: assert property (s.st == TSQ_NEXT && s.cont
    && !cmd_abort |=> s.st == TSQ_EVENT)
    else $error("continuous mode did not re-arm");
  a_abort_idle: assert property (cmd_abort |=> s.st == TSQ_IDLE
    && idle) else $error("stop request did not force idle");
  a_imm_pass: assert property (s.st == TSQ_EVENT
    && s.src == TSQ_SRC_IMM && !cmd_abort |=> s.st == TSQ_DELAY)
    else $error("immediate source did not pass");
  a_key_remote: assert property (s.st == TSQ_EVENT
    && s.src == TSQ_SRC_KEY && s.remote |=> s.st != TSQ_DELAY)
    else $error("front key honoured in remote");
  a_timer_clear: assert property (s.st == TSQ_IDLE |=> s.tmr == '0)
    else $error("interval timer not cleared in idle");
  a_zero_delay: assert property (s.st == TSQ_DELAY && !s.auto_dly
    && s.delay == '0 && !cmd_abort |=> s.st == TSQ_CONV ##1 conv_start)
    else $error("zero delay not passed at once");
  a_single_conv: assert property (s.st == TSQ_WAIT && conv_valid
    && !s.filt_rep && !s.hold_en && !cmd_abort |=> rdg_valid
    && rdg == $past(conv_value))
    else $error("single conversion not reported");
  a_beep_release: assert property (beep |-> s.hold_en
    && $past(s.hcnt) + 7'h01 >= s.hold_n && rdg_valid)
    else $error("alert without settle release");
  a_open_close: assert property (chan.open && !cmd_abort
    |=> chan.close && chan.num != $past(chan.num) || s.chan_last == 8'h01)
    else $error("channel open not followed by close");
  a_holdn_range: assert property (s.hold_n >= `TSQ_HOLDN_MIN
    && s.hold_n <= `TSQ_HOLDN_MAX)
    else $error("settle count out of range");
  a_idle_return: assert property (s.st == TSQ_NEXT && !s.cont
    && !s.scan_en |=> s.st == TSQ_IDLE)
    else $error("single pass did not return to idle");

  c_beep:   cover property (beep);
  c_scan:   cover property (chan.open ##1 chan.close);
  c_timer:  cover property (s.st == TSQ_EVENT && s.src == TSQ_SRC_TIMER
                            && !s.first ##1 s.st == TSQ_DELAY);
  c_filter: cover property (s.filt_rep && rdg_valid);

endmodule // tsq_core

// ### dv/tsq_fe_model.sv
// front-end converter model standing behind the sequencer
// assumes conv_start is a one-cycle pulse on mclk, one conversion at a time
`timescale 1ns/100ps
module tsq_fe_model #(
  parameter int LAT = 3 // cycles from start to result
) (
  input  wire logic               mclk,       // system clock
  input  wire logic               rst_n,      // async reset, active low
  input  wire logic               conv_start, // start request
  input  wire logic signed [23:0] val,        // value to report
  output      logic               conv_valid, // result strobe
  output      logic signed [23:0] conv_value  // result, junk off strobe
);
  int cnt;
  // count down then strobe once; value churns off the strobe so a
  // sequencer sampling it one cycle late sees the inverted result, not a stale but plausible one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      conv_valid <= 1'b0;
      conv_value <= 24'sh0;
    end else begin
      conv_valid <= (cnt == 1);
      conv_value <= (cnt == 1) ? val : ~conv_value;
      if (conv_start) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule // tsq_fe_model

// ### dv/tb_top.sv
// self-checking bench for the trigger sequencer
// assumes tsq_core with a 10-cycle millisecond and the converter model
`timescale 1ns/100ps
`include "tsq_defines.svh"
module tb_top;
  import tsq_pkg::*;
  logic               mclk = 0, rst_n = 0, fire_key = 0, ext_front_panel_fire_key = 0;
  tsq_bus_s           bus = '0;
  logic [31:0]        rdata;
  logic               conv_start, conv_valid, rdg_valid, beep, idle;
  logic signed [23:0] conv_value, rdg, val = 0;
  logic signed [23:0] vals [16];
  tsq_chan_s          chan;
  logic [7:0]         lastnum;
  logic               idle_q;
  int bad_count = 0, total_checks = 0, cyc = 0, vi = 0, t0, tconv, gap;
  int nconv, nrdg, nbeep, nopen, nclose, nidle;
  int stops [4] = '{2, 8, 16, 32};

  tsq_core #(.MS_CYCLES(10)) dut (.mclk, .rst_n, .bus, .rdata, .fire_key,
    .ext_front_panel_fire_key, .conv_start, .conv_valid, .conv_value, .rdg_valid, .rdg,
    .beep, .chan, .idle);
  tsq_fe_model fe (.mclk, .rst_n, .conv_start, .val, .conv_valid,
    .conv_value);

  always #5 mclk = ~mclk;

  // event counters, converter values and the hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (conv_start) begin
      nconv <= nconv + 1;
      val <= vals[vi];
      vi <= vi + 1;
      tconv <= cyc;
      gap <= cyc - tconv;
    end
    if (rdg_valid) nrdg <= nrdg + 1;
    if (beep) nbeep <= nbeep + 1;
    if (chan.open) nopen <= nopen + 1;
    if (chan.close) nclose <= nclose + 1;
    if (chan.close) lastnum <= chan.num;
    // rises of idle; a steady idle never counts, so clr cannot race it
    idle_q <= idle;
    if (idle && !idle_q) nidle <= nidle + 1;
    if (cyc > 20000) begin
      bad_count++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // an edge passes after the strobe drops, so a following call never
  // lowers and raises a strobe in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, e);
    @(posedge mclk);
  endtask

  task automatic shot(input logic [31:0] c);
    wr(`TSQ_REG_CTRL, c);
    wr(`TSQ_REG_CMD, 32'h1);
  endtask

  // counters are cleared only while the sequencer is idle
  task automatic clr(input logic signed [23:0] a, b, c);
    nconv = 0; nrdg = 0; nbeep = 0; nopen = 0; nclose = 0; vi = 0; nidle = 0;
    vals = '{default: c};
    vals[0] = a;
    vals[1] = b;
  endtask

  task automatic wfor(input int n);
    for (int k = 0; k < 400 && nrdg < n; k++) @(posedge mclk);
    chk(32'(nrdg >= n), 32'h1);
  endtask

  task automatic widle;
    for (int k = 0; k < 60 && idle !== 1'b1; k++) @(posedge mclk);
    chk(32'(idle), 32'h1);
  endtask

  task automatic pulse(input bit ext);
    if (ext) ext_front_panel_fire_key <= 1'b1;
    else fire_key <= 1'b1;
    wcyc(4);
    ext_front_panel_fire_key <= 1'b0;
    fire_key <= 1'b0;
  endtask

  initial begin
    clr(0, 0, 0);
    wcyc(2);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`TSQ_REG_INTERVAL, 32'h64);
    rd(8'h30, 32'h0);
    wr(`TSQ_REG_INTERVAL, 32'h0);
    rd(`TSQ_REG_INTERVAL, 32'h1);
    wcyc(10);
    chk(nconv, 0);
    chk(32'(idle), 32'h1);
    // one immediate shot, no filter
    clr(24'sh123, 0, 0);
    shot(0);
    wfor(1);
    widle;
    chk(nconv, 1);
    chk(32'(rdg), 32'h123);
    // repeat filter, mean truncated toward zero
    wr(`TSQ_REG_FILT, 3);
    clr(-10, -20, -44);
    shot(32'h40);
    wfor(1);
    widle;
    chk(nconv, 3);
    chk(32'(rdg), -24);
    // programmed 2 ms then automatic 4 ms delay
    wr(`TSQ_REG_DELAY, 2);
    shot(0);
    t0 = cyc;
    wfor(nrdg + 1);
    chk(32'(tconv - t0 >= 14 && tconv - t0 <= 26), 32'h1);
    widle;
    shot(32'h410);
    t0 = cyc;
    wfor(nrdg + 1);
    chk(32'(tconv - t0 >= 34 && tconv - t0 <= 48), 32'h1);
    widle;
    wr(`TSQ_REG_DELAY, 0);
    // bus source ignores the sync pin, fires on the bus trigger
    clr(0, 0, 0);
    shot(32'h8);
    pulse(1);
    wcyc(12);
    chk(nconv, 0);
    wr(`TSQ_REG_CMD, 32'h4);
    wfor(1);
    widle;
    // external source
    shot(32'h6);
    wcyc(12);
    chk(nconv, 1);
    pulse(1);
    wfor(2);
    widle;
    // key refused in remote, honoured in local
    shot(32'h102);
    pulse(0);
    wcyc(12);
    chk(nconv, 2);
    wr(`TSQ_REG_CTRL, 32'h2);
    pulse(0);
    wfor(3);
    widle;
    // every stop request forces idle mid-sequence
    for (int i = 0; i < 4; i++) begin
      clr(0, 0, 0);
      shot(32'h8);
      wcyc(3);
      wr(`TSQ_REG_CMD, stops[i]);
      wcyc(2);
      chk(32'(idle), 32'h1);
      wr(`TSQ_REG_CMD, 32'h4);
      wcyc(12);
      chk(nconv, 0);
    end
    // continuous mode re-arms without idling; an abort drops it to idle
    // for one cycle only, as continuous mode is still on afterwards
    clr(0, 0, 0);
    wr(`TSQ_REG_CTRL, 32'h1);
    wfor(3);
    chk(nidle, 0);
    wr(`TSQ_REG_CMD, 32'h2);
    wcyc(1);
    chk(nidle, 1);
    wr(`TSQ_REG_CTRL, 32'h0);
    widle;
    // settle check: reseed on the outlier, release after two in-window
    wr(`TSQ_REG_HOLDN, 2);
    clr(1000, 1000, 5000);
    shot(32'h80);
    wfor(1);
    widle;
    chk(nbeep, 1);
    chk(nrdg, 1);
    chk(32'(rdg), 32'd5000);
    chk(32'(nconv >= 5), 32'h1);
    // scan over two channels
    wr(`TSQ_REG_CHLAST, 2);
    clr(0, 0, 0);
    shot(32'h20);
    wfor(2);
    widle;
    chk(nclose, 2);
    chk(nopen, 1);
    chk(lastnum, 2);
    // interval source while scanning, 3 ms apart after the first pass
    wr(`TSQ_REG_INTERVAL, 3);
    clr(0, 0, 0);
    shot(32'h24);
    wfor(2);
    widle;
    chk(32'(gap >= 20 && gap <= 40), 32'h1);
    test_done;
  end
endmodule // tb_top
